// File: common/gesture_pkg.sv
package gesture_pkg;

	// clock and time base
	localparam int CLK_PERIOD_NS = 100;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MS_PER_S      = 1000;
	localparam int PULSE_MS      = 100;
	localparam int SCAN_MS       = 1;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_TAPDLY   = 8'h04;
	localparam logic [7:0] OFF_DTAPDLY  = 8'h08;
	localparam logic [7:0] OFF_LONGDLY  = 8'h0C;
	localparam logic [7:0] OFF_SCANIVL  = 8'h10;
	localparam logic [7:0] OFF_CALSTART = 8'h14;
	localparam logic [7:0] OFF_CALFINAL = 8'h18;
	localparam logic [7:0] OFF_CALTRANS = 8'h1C;
	localparam logic [7:0] OFF_RXMASK   = 8'h20;
	localparam logic [7:0] OFF_STATUS   = 8'h24;
	localparam logic [7:0] OFF_WHEEL    = 8'h28;
	localparam logic [7:0] OFF_IRQSTAT  = 8'h2C;
	localparam logic [7:0] OFF_IRQMASK  = 8'h30;
	localparam logic [7:0] OFF_PINCFG0  = 8'h34;

	// reset values
	localparam logic [9:0]  RST_TAPDLY   = 10'h12C;
	localparam logic [9:0]  RST_DTAPDLY  = 10'h190;
	localparam logic [9:0]  RST_LONGDLY  = 10'h320;
	localparam logic [7:0]  RST_SCANIVL  = 8'h64;
	localparam logic [10:0] RST_CALSTART = 11'h002;
	localparam logic [10:0] RST_CALFINAL = 11'h00A;
	localparam logic [15:0] RST_CALTRANS = 16'h0078;
	localparam logic [4:0]  RST_RXMASK   = 5'h01;

	// event vector layout
	localparam int EV_TOUCH = 0;
	localparam int EV_TAP   = 5;
	localparam int EV_DTAP  = 10;
	localparam int EV_LONG  = 15;
	localparam int EV_CW    = 20;
	localparam int EV_CCW   = 21;
	localparam int EV_WHEEL = 22;
	localparam int EV_WAKE  = 23;
	localparam int EV_COUNT = 24;

	typedef enum logic [2:0] {
		ACT_HIGH   = 3'b000,
		ACT_LOW    = 3'b001,
		ACT_TOGGLE = 3'b010,
		ACT_PULSE  = 3'b011,
		ACT_LVL_HI = 3'b100,
		ACT_LVL_LO = 3'b101
	} pin_action_t;

	typedef enum logic [1:0] {
		ST_PROCESS  = 2'b00,
		ST_SLEEP    = 2'b01,
		ST_APPROACH = 2'b10,
		ST_CALIB    = 2'b11
	} sched_state_t;

endpackage

// File: design/touch_tap_tracker.sv
`timescale 1ns/1ps
`default_nettype none

module touch_tap_tracker (
	input  wire logic       mclk,      // system clock
	input  wire logic       rstn,      // sync reset, active low
	input  wire logic       touch,     // synchronised touch level
	input  wire logic       msTick,    // 1 ms tick
	input  wire logic [9:0] tapDelay,  // tap limit in ms
	input  wire logic [9:0] dtapDelay, // double tap window in ms
	input  wire logic [9:0] longDelay, // long touch limit in ms
	output logic            touchEvt,  // touch onset pulse
	output logic            tapEvt,    // single tap pulse
	output logic            dtapEvt,   // double tap pulse
	output logic            longEvt    // long touch release pulse
);
	logic        touchQ;
	logic [10:0] holdMs;
	logic [10:0] gapMs;
	logic        tapPending;
	logic        rise;
	logic        fall;
	logic        isTap;
	logic        inWindow;

	assign rise     = touch & ~touchQ;
	assign fall     = ~touch & touchQ;
	assign isTap    = holdMs < {1'b0, tapDelay};
	assign inWindow = tapPending && (gapMs < {1'b0, dtapDelay});

	// touch duration, saturating
	always_ff @(posedge mclk)
	begin
		if (!rstn)
			holdMs <= 11'h000;
		else if (rise)
			holdMs <= 11'h000;
		else if (touch && msTick && holdMs != 11'h7FF)
			holdMs <= holdMs + 11'h001;
	end

	// events, one cycle each
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			touchQ   <= 1'b0;
			touchEvt <= 1'b0;
			tapEvt   <= 1'b0;
			dtapEvt  <= 1'b0;
			longEvt  <= 1'b0;
		end
		else
		begin
			touchQ   <= touch;
			touchEvt <= rise;
			tapEvt   <= fall && isTap;
			dtapEvt  <= fall && isTap && inWindow;
			longEvt  <= fall && holdMs >= {1'b0, longDelay};
		end
	end

	// a tap that completes a pair does not open a new window
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			tapPending <= 1'b0;
			gapMs      <= 11'h000;
		end
		else if (fall && isTap)
		begin
			tapPending <= !inWindow;
			gapMs      <= 11'h000;
		end
		else if (tapPending && msTick)
		begin
			if (gapMs >= {1'b0, dtapDelay})
				tapPending <= 1'b0;
			else
				gapMs <= gapMs + 11'h001;
		end
	end
endmodule

`default_nettype wire

// File: design/event_pin_driver.sv
`timescale 1ns/1ps
`default_nettype none

module event_pin_driver (
	input  wire logic       mclk,   // system clock
	input  wire logic       rstn,   // sync reset, active low
	input  wire logic       enable, // pin mapping on
	input  wire logic [2:0] action, // pin_action_t code
	input  wire logic       fire,   // mapped event pulse
	input  wire logic       level,  // mapped event level
	input  wire logic       msTick, // 1 ms tick
	output logic            pinOut  // event output pin
);
	localparam logic [6:0] PULSE_LEN = 7'(gesture_pkg::PULSE_MS);

	logic [6:0] pulseMs;

	// one action per mapped pin
	always_ff @(posedge mclk)
	begin
		if (!rstn || !enable)
		begin
			pinOut  <= 1'b0;
			pulseMs <= 7'h00;
		end
		else
		begin
			case (action)
				gesture_pkg::ACT_HIGH:
					if (fire)
						pinOut <= 1'b1;
				gesture_pkg::ACT_LOW:
					if (fire)
						pinOut <= 1'b0;
				gesture_pkg::ACT_TOGGLE:
					if (fire)
						pinOut <= ~pinOut;
				gesture_pkg::ACT_PULSE:
					// a new event restarts the full width
					if (fire)
					begin
						pinOut  <= 1'b1;
						pulseMs <= PULSE_LEN;
					end
					else if (pulseMs != 7'h00 && msTick)
					begin
						pulseMs <= pulseMs - 7'h01;
						if (pulseMs == 7'h01)
							pinOut <= 1'b0;
					end
				gesture_pkg::ACT_LVL_HI:
					pinOut <= level;
				gesture_pkg::ACT_LVL_LO:
					pinOut <= ~level;
				default:
					pinOut <= 1'b0;
			endcase
		end
	end
endmodule

`default_nettype wire

// File: design/gesture_event_port.sv
// Contract
// - any feature event may be routed to any of five event output pins.
// - pin action per mapping: high, low, toggle, 100 ms pulse, level modes.
// - single tap only when touch-to-release is below tap delay (0 to 1 s).
// - double tap when two taps fall within double-tap interval (0 to 1 s).
// - touch state is tracked independently on up to five electrodes.
// - every touch raises an event and is classed short or long; the code gives tap below tap delay, long at or above long delay, none between.
// - rotary counter counts up clockwise, down counterclockwise, live.
// - discrete circle result given only after motion stops or hand leaves.
// - approach mode sleeps and alternates sleep and scan phases.
// - approach scans spaced by set interval; one channel default, more by mask.
// - active channel over threshold in scan wakes to processing, tells host.
// - calibration scans enable all five channels, every 2 s to 1024 s.
// - calibration uses start interval until timeout, then final interval.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module gesture_event_port #(
	parameter int MS_CYCLES = gesture_pkg::MS_CYCLES // clocks per ms tick
) (
	input  wire logic        mclk,        // system clock, 10 MHz
	input  wire logic        rstn,        // sync reset, active low
	input  wire logic        psel,        // APB select
	input  wire logic        penable,     // APB enable
	input  wire logic        pwrite,      // APB direction
	input  wire logic [7:0]  paddr,       // APB byte address
	input  wire logic [31:0] pwdata,      // APB write data
	output logic      [31:0] prdata,      // APB read data
	output logic             pready,      // APB ready
	output logic             pslverr,     // APB error, unmapped
	input  wire logic [4:0]  touchIn,     // electrode touch levels
	input  wire logic        circleFound, // discrete circle seen
	input  wire logic        circleCw,    // its direction, 1 = cw
	input  wire logic        motionOn,    // hand is moving
	input  wire logic        handPresent, // hand in detection area
	input  wire logic        wheelOn,     // continuous circling
	input  wire logic        wheelStepCw, // rotation step cw
	input  wire logic        wheelStepCcw,// rotation step ccw
	input  wire logic [4:0]  rxExceed,    // channel over threshold
	output logic      [4:0]  eventPin,    // event output pins
	output logic      [4:0]  rxEnable,    // receive channels on
	output logic             scanActive,  // scan phase running
	output logic             sleepState,  // low power sleep
	output logic             hostWake,    // wake pulse to host
	output logic             irq          // interrupt, active high
);
	localparam int NPIN = 17;

	if (MS_CYCLES < 2 || MS_CYCLES > 65535)
	begin : g_chk
		$error("MS_CYCLES out of range");
	end

	////////////////////////////////////////////////////////////////////
	// pin synchronisers and edges

	logic [NPIN-1:0] syncA;
	logic [NPIN-1:0] syncB;
	logic [NPIN-1:0] syncC;
	logic [4:0]      touchSync;
	logic [4:0]      rxSync;
	logic            foundRise;
	logic            motionFall;
	logic            handFall;
	logic            cwRise;
	logic            ccwRise;

	// two flops before use, third for edges
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			syncA <= '0;
			syncB <= '0;
			syncC <= '0;
		end
		else
		begin
			syncA <= {rxExceed, wheelStepCcw, wheelStepCw, wheelOn,
				handPresent, motionOn, circleCw, circleFound, touchIn};
			syncB <= syncA;
			syncC <= syncB;
		end
	end

	assign touchSync  = syncB[4:0];
	assign rxSync     = syncB[16:12];
	assign foundRise  = syncB[5] & ~syncC[5];
	assign motionFall = ~syncB[7] & syncC[7];
	assign handFall   = ~syncB[8] & syncC[8];
	assign cwRise     = syncB[10] & ~syncC[10];
	assign ccwRise    = syncB[11] & ~syncC[11];

	////////////////////////////////////////////////////////////////////
	// time base

	logic [15:0] msDiv;
	logic [9:0]  secDiv;
	logic        msTick;
	logic        secTick;

	// ms and s ticks, restarted by reset
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			msDiv   <= 16'h0000;
			secDiv  <= 10'h000;
			msTick  <= 1'b0;
			secTick <= 1'b0;
		end
		else
		begin
			msTick  <= msDiv == 16'(MS_CYCLES - 1);
			secTick <= msTick && secDiv == 10'(gesture_pkg::MS_PER_S - 1);
			if (msDiv == 16'(MS_CYCLES - 1))
				msDiv <= 16'h0000;
			else
				msDiv <= msDiv + 16'h0001;
			if (msTick)
				secDiv <= (secDiv == 10'(gesture_pkg::MS_PER_S - 1)) ?
					10'h000 : secDiv + 10'h001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers

	logic [1:0]  ctrl;
	logic [9:0]  tapDelay;
	logic [9:0]  dtapDelay;
	logic [9:0]  longDelay;
	logic [7:0]  scanIvl;
	logic [10:0] calStart;
	logic [10:0] calFinal;
	logic [15:0] calTrans;
	localparam int EV_W = gesture_pkg::EV_COUNT;

	logic [4:0]  rxMask;
	logic [8:0]  pinCfg [5];
	logic [EV_W-1:0] irqStat;
	logic [EV_W-1:0] irqMask;
	logic        wrEn;

	assign wrEn = psel && penable && pready && pwrite;

	function automatic logic [7:0] pinOff(input int i);
		pinOff = gesture_pkg::OFF_PINCFG0 + 8'(i * 4);
	endfunction

	// software-set configuration
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			ctrl      <= 2'b00;
			tapDelay  <= gesture_pkg::RST_TAPDLY;
			dtapDelay <= gesture_pkg::RST_DTAPDLY;
			longDelay <= gesture_pkg::RST_LONGDLY;
			scanIvl   <= gesture_pkg::RST_SCANIVL;
			calStart  <= gesture_pkg::RST_CALSTART;
			calFinal  <= gesture_pkg::RST_CALFINAL;
			calTrans  <= gesture_pkg::RST_CALTRANS;
			rxMask    <= gesture_pkg::RST_RXMASK;
			irqMask   <= '0;
			for (int i = 0; i < 5; i++)
				pinCfg[i] <= 9'h000;
		end
		else if (wrEn)
		begin
			if (paddr == gesture_pkg::OFF_CTRL)
				ctrl <= pwdata[1:0];
			else if (paddr == gesture_pkg::OFF_TAPDLY)
				tapDelay <= pwdata[9:0];
			else if (paddr == gesture_pkg::OFF_DTAPDLY)
				dtapDelay <= pwdata[9:0];
			else if (paddr == gesture_pkg::OFF_LONGDLY)
				longDelay <= pwdata[9:0];
			else if (paddr == gesture_pkg::OFF_SCANIVL)
				scanIvl <= pwdata[7:0];
			else if (paddr == gesture_pkg::OFF_CALSTART)
				calStart <= pwdata[10:0];
			else if (paddr == gesture_pkg::OFF_CALFINAL)
				calFinal <= pwdata[10:0];
			else if (paddr == gesture_pkg::OFF_CALTRANS)
				calTrans <= pwdata[15:0];
			else if (paddr == gesture_pkg::OFF_RXMASK)
				rxMask <= pwdata[4:0];
			else if (paddr == gesture_pkg::OFF_IRQMASK)
				irqMask <= pwdata[EV_W-1:0];
			for (int i = 0; i < 5; i++)
				if (paddr == pinOff(i))
					pinCfg[i] <= pwdata[8:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// touch trackers, one per electrode

	logic [4:0] touchEvt;
	logic [4:0] tapEvt;
	logic [4:0] dtapEvt;
	logic [4:0] longEvt;

	for (genvar e = 0; e < 5; e++)
	begin : g_touch
		touch_tap_tracker u_trk (
			.mclk      (mclk),
			.rstn      (rstn),
			.touch     (touchSync[e]),
			.msTick    (msTick),
			.tapDelay  (tapDelay),
			.dtapDelay (dtapDelay),
			.longDelay (longDelay),
			.touchEvt  (touchEvt[e]),
			.tapEvt    (tapEvt[e]),
			.dtapEvt   (dtapEvt[e]),
			.longEvt   (longEvt[e])
		);
	end

	////////////////////////////////////////////////////////////////////
	// circles

	logic        circlePending;
	logic        circleDir;
	logic        cwEvt;
	logic        ccwEvt;
	logic        wheelEvt;
	logic [15:0] wheelCount;
	logic        circleDone;

	// hold the result back until the hand stops or leaves
	assign circleDone = circlePending && (motionFall || handFall);

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			circlePending <= 1'b0;
			circleDir     <= 1'b0;
			cwEvt         <= 1'b0;
			ccwEvt        <= 1'b0;
		end
		else
		begin
			cwEvt  <= circleDone && circleDir;
			ccwEvt <= circleDone && !circleDir;
			if (foundRise)
			begin
				circlePending <= 1'b1;
				circleDir     <= syncB[6];
			end
			else if (circleDone)
				circlePending <= 1'b0;
		end
	end

	// steps in both directions at once cancel
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			wheelCount <= 16'h0000;
			wheelEvt   <= 1'b0;
		end
		else
		begin
			wheelEvt <= syncB[9] && (cwRise ^ ccwRise);
			if (syncB[9] && cwRise && !ccwRise)
				wheelCount <= wheelCount + 16'h0001;
			else if (syncB[9] && ccwRise && !cwRise)
				wheelCount <= wheelCount - 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// approach scheduler

	gesture_pkg::sched_state_t state;
	logic [7:0]  scanMs;
	logic [10:0] calSec;
	logic [15:0] idleSec;
	logic [3:0]  phaseMs;
	logic [10:0] calIvl;
	logic        wakeEvt;

	// start rate until the idle timeout, then final rate
	assign calIvl = (idleSec >= calTrans) ? calFinal : calStart;

	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			state   <= gesture_pkg::ST_PROCESS;
			scanMs  <= 8'h00;
			calSec  <= 11'h000;
			idleSec <= 16'h0000;
			phaseMs <= 4'h0;
			wakeEvt <= 1'b0;
		end
		else
		begin
			wakeEvt <= 1'b0;
			if (state != gesture_pkg::ST_PROCESS && msTick)
				scanMs <= scanMs + 8'h01;
			if (state != gesture_pkg::ST_PROCESS && secTick)
			begin
				calSec <= calSec + 11'h001;
				if (idleSec != 16'hFFFF)
					idleSec <= idleSec + 16'h0001;
			end
			case (state)
				gesture_pkg::ST_PROCESS:
					if (ctrl[0] && !syncB[8])
					begin
						state   <= gesture_pkg::ST_SLEEP;
						scanMs  <= 8'h00;
						calSec  <= 11'h000;
						idleSec <= 16'h0000;
					end
				gesture_pkg::ST_SLEEP:
					if (!ctrl[0])
						state <= gesture_pkg::ST_PROCESS;
					else if (calSec >= calIvl)
					begin
						state   <= gesture_pkg::ST_CALIB;
						calSec  <= 11'h000;
						phaseMs <= 4'h0;
					end
					else if (scanMs >= scanIvl)
					begin
						state   <= gesture_pkg::ST_APPROACH;
						scanMs  <= 8'h00;
						phaseMs <= 4'h0;
					end
				gesture_pkg::ST_APPROACH:
					if ((rxSync & rxMask) != 5'h00)
					begin
						state   <= gesture_pkg::ST_PROCESS;
						wakeEvt <= 1'b1;
					end
					else if (msTick)
					begin
						phaseMs <= phaseMs + 4'h1;
						if (phaseMs == 4'(gesture_pkg::SCAN_MS - 1))
							state <= gesture_pkg::ST_SLEEP;
					end
				gesture_pkg::ST_CALIB:
					// threshold is not judged while calibrating
					if (msTick)
					begin
						phaseMs <= phaseMs + 4'h1;
						if (phaseMs == 4'(gesture_pkg::SCAN_MS - 1))
							state <= gesture_pkg::ST_SLEEP;
					end
				default:
					state <= gesture_pkg::ST_PROCESS;
			endcase
		end
	end

	// scheduler outputs, registered
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			rxEnable   <= 5'h00;
			scanActive <= 1'b0;
			sleepState <= 1'b0;
			hostWake   <= 1'b0;
		end
		else
		begin
			scanActive <= state == gesture_pkg::ST_APPROACH ||
				state == gesture_pkg::ST_CALIB;
			sleepState <= state == gesture_pkg::ST_SLEEP;
			hostWake   <= wakeEvt && ctrl[1];
			if (state == gesture_pkg::ST_CALIB)
				rxEnable <= 5'h1F;
			else if (state == gesture_pkg::ST_APPROACH)
				rxEnable <= rxMask;
			else
				rxEnable <= 5'h00;
		end
	end

	////////////////////////////////////////////////////////////////////
	// event vector, pin mapping and interrupt

	logic [EV_W-1:0] evPulse;
	logic [EV_W-1:0] evLevel;

	assign evPulse = {wakeEvt, wheelEvt, ccwEvt, cwEvt,
		longEvt, dtapEvt, tapEvt, touchEvt};
	assign evLevel = {evPulse[EV_W-1:5], touchSync};

	function automatic logic pick(input logic [EV_W-1:0] v,
		input logic [4:0] sel);
		pick = (int'(sel) < EV_W) ? v[sel] : 1'b0;
	endfunction

	for (genvar p = 0; p < 5; p++)
	begin : g_pin
		event_pin_driver u_drv (
			.mclk   (mclk),
			.rstn   (rstn),
			.enable (pinCfg[p][8]),
			.action (pinCfg[p][7:5]),
			.fire   (pick(evPulse, pinCfg[p][4:0])),
			.level  (pick(evLevel, pinCfg[p][4:0])),
			.msTick (msTick),
			.pinOut (eventPin[p])
		);
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			irqStat <= '0;
			irq     <= 1'b0;
		end
		else
		begin
			if (wrEn && paddr == gesture_pkg::OFF_IRQSTAT)
				irqStat <= (irqStat & ~pwdata[EV_W-1:0]) | evPulse;
			else
				irqStat <= irqStat | evPulse;
			irq <= |(irqStat & irqMask);
		end
	end

	////////////////////////////////////////////////////////////////////
	// APB read path: data captured in setup, answered in access

	logic [31:0] rdNext;
	logic        errNext;

	always_comb
	begin
		rdNext  = 32'h0000_0000;
		errNext = 1'b0;
		if (paddr == gesture_pkg::OFF_CTRL)
			rdNext = {30'h0, ctrl};
		else if (paddr == gesture_pkg::OFF_TAPDLY)
			rdNext = {22'h0, tapDelay};
		else if (paddr == gesture_pkg::OFF_DTAPDLY)
			rdNext = {22'h0, dtapDelay};
		else if (paddr == gesture_pkg::OFF_LONGDLY)
			rdNext = {22'h0, longDelay};
		else if (paddr == gesture_pkg::OFF_SCANIVL)
			rdNext = {24'h0, scanIvl};
		else if (paddr == gesture_pkg::OFF_CALSTART)
			rdNext = {21'h0, calStart};
		else if (paddr == gesture_pkg::OFF_CALFINAL)
			rdNext = {21'h0, calFinal};
		else if (paddr == gesture_pkg::OFF_CALTRANS)
			rdNext = {16'h0, calTrans};
		else if (paddr == gesture_pkg::OFF_RXMASK)
			rdNext = {27'h0, rxMask};
		else if (paddr == gesture_pkg::OFF_STATUS)
			rdNext = {24'h0, state, circlePending, touchSync};
		else if (paddr == gesture_pkg::OFF_WHEEL)
			rdNext = {16'h0, wheelCount};
		else if (paddr == gesture_pkg::OFF_IRQSTAT)
			rdNext = {8'h0, irqStat};
		else if (paddr == gesture_pkg::OFF_IRQMASK)
			rdNext = {8'h0, irqMask};
		else if (paddr >= gesture_pkg::OFF_PINCFG0 &&
			paddr <= pinOff(4) && paddr[1:0] == 2'b00)
			rdNext = {23'h0, pinCfg[3'((paddr - gesture_pkg::OFF_PINCFG0) >> 2)]};
		else
			errNext = 1'b1;
	end

	// one access cycle per transfer, no wait states
	always_ff @(posedge mclk)
	begin
		if (!rstn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && errNext;
			if (psel && !penable && !pwrite)
				prdata <= rdNext;
		end
	end
endmodule

`default_nettype wire

// File: test/gesture_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module gesture_monitor #(
	parameter int MS_CYCLES = gesture_pkg::MS_CYCLES // clocks per ms tick
) (
	input wire logic        mclk,       // clock
	input wire logic        rstn,       // sync reset
	input wire logic        psel,       // apb select
	input wire logic        penable,    // apb enable
	input wire logic        pwrite,     // apb direction
	input wire logic [31:0] prdata,     // read data
	input wire logic        pready,     // ready
	input wire logic        pslverr,    // error
	input wire logic [4:0]  rxEnable,   // channels on
	input wire logic        scanActive, // scan phase
	input wire logic        sleepState, // sleep
	input wire logic        hostWake    // wake pulse
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	int scanLen;
	// a stuck scan phase would burn power forever, so bound it
	always_ff @(posedge mclk)
		scanLen <= (scanActive && rstn) ? scanLen + 1 : 0;
	a_ready_next: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read not zero");
	a_idle_rx: assert property (!scanActive |-> rxEnable == 5'h00)
		else $error("channel on outside scan");
	a_scan_origin: assert property ($rose(scanActive) |-> $past(sleepState))
		else $error("scan not from sleep");
	a_scan_len: assert property (scanLen <= 2 * MS_CYCLES + 2)
		else $error("scan phase too long");
	a_wake_pulse: assert property (hostWake |=> !hostWake)
		else $error("wake pulse too long");
	a_wake_stop: assert property (hostWake |-> ##[0:3] !scanActive)
		else $error("scan kept after wake");
	c_refused: cover property (pready && pslverr);
	c_wake: cover property (hostWake);
	c_calib: cover property (rxEnable == 5'h1F);
endmodule
bind gesture_event_port gesture_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
	.mclk, .rstn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
	.rxEnable, .scanActive, .sleepState, .hostWake
);
`default_nettype wire

// File: test/pin_watcher.sv
`timescale 1ns/1ps
`default_nettype none
module pin_watcher (
	input wire logic       mclk,     // system clock
	input wire logic       rstn,     // sync reset, active low
	input wire logic [4:0] eventPin, // pins from the device
	output int             rises     // rising edges seen
);
	logic [4:0] last;
	// host side only listens, it never drives the pins
	always_ff @(posedge mclk)
	begin
		// idle level of the pins is low, so no false edge after reset
		if (!rstn)
		begin
			last <= 5'h00;
			rises <= 0;
		end
		else
		begin
			last <= eventPin;
			rises <= rises + $countones(eventPin & ~last);
		end
	end
endmodule
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, sn) \
	begin \
		checks++; \
		if ((sn) !== (ex)) \
		begin \
			miscompares++; \
			$display("MISMATCH %s exp %0h got %0h", nm, ex, sn); \
		end \
	end
module tb_top;
	localparam int MS = 10; // shortened ms tick
	logic mclk, rstn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0] touchIn, rxExceed, eventPin, rxEnable;
	logic circleFound, circleCw, motionOn, handPresent, wheelOn;
	logic wheelStepCw, wheelStepCcw, scanActive, sleepState, hostWake, irq;
	logic er;
	int miscompares, checks, n, rises;
	logic [31:0] rv [8] = '{32'h12C, 32'h190, 32'h320, 32'h64,
		32'h2, 32'hA, 32'h78, 32'h1};
	logic [2:0] ord [6] = '{3'h1, 3'h2, 3'h0, 3'h4, 3'h5, 3'h3};
	logic [5:0] held = 6'b011101;
	logic [5:0] rel = 6'b101101;
	gesture_event_port #(.MS_CYCLES(MS)) u_dut (
		.mclk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .touchIn, .circleFound, .circleCw, .motionOn,
		.handPresent, .wheelOn, .wheelStepCw, .wheelStepCcw, .rxExceed,
		.eventPin, .rxEnable, .scanActive, .sleepState, .hostWake, .irq
	);
	pin_watcher u_host (.mclk, .rstn, .eventPin, .rises);
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic wt(input int c);
		repeat (c) @(posedge mclk);
	endtask
	// one full apb transfer, held until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int t;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		t = 0;
		do @(posedge mclk); while (pready !== 1'b1 && ++t < 20);
		rd = prdata;
		er = pslverr;
		`CHK("ready", 1'b1, pready)
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK("register", e, rd)
	endtask
	task automatic tap(input int ms);
		touchIn[1] <= 1'b1;
		wt(ms * MS);
		touchIn[1] <= 1'b0;
		wt(2 * MS);
	endtask
	function automatic logic cond(input int w);
		case (w)
			0: return scanActive === 1'b1;
			1: return scanActive !== 1'b1;
			2: return rxEnable === 5'h1F;
			default: return hostWake === 1'b1;
		endcase
	endfunction
	// bounded wait, the count is kept in n for timing checks
	task automatic waitfor(input int w, input int lim);
		n = 0;
		while (!cond(w) && n < lim)
		begin
			@(posedge mclk);
			n++;
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (40000) @(posedge mclk);
		miscompares++;
		end_of_test();
	end
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{touchIn, rxExceed, circleFound, circleCw, motionOn} = '0;
		{handPresent, wheelOn, wheelStepCw, wheelStepCcw} = '0;
		rstn = 1'b0;
		wt(2);
		rstn <= 1'b1;
		@(posedge mclk);
		for (int i = 0; i < 8; i++)
			rdchk(8'(4 * i + 4), rv[i]);
		apb(1'b0, 8'h48, 32'h0);
		`CHK("refused", 32'h0, rd)
		`CHK("refused err", 1'b1, er)
		// every action on pin 3, fired by touch onset of electrode 3, the level modes following its touch level
		foreach (ord[i])
		begin
			apb(1'b1, 8'h40, {23'h0, 1'b1, ord[i], 5'h03});
			touchIn[3] <= 1'b1;
			wt(10);
			`CHK("pin held", held[ord[i]], eventPin[3])
			touchIn[3] <= 1'b0;
			wt(10);
			`CHK("pin released", rel[ord[i]], eventPin[3])
		end
		wt(95 * MS - 20);
		`CHK("pulse on", 1'b1, eventPin[3])
		wt(10 * MS);
		`CHK("pulse off", 1'b0, eventPin[3])
		for (int i = 0; i < 5; i++)
			apb(1'b1, 8'(8'h34 + 4 * i), {23'h0, 1'b1, 3'h4, 5'(i)});
		n = rises;
		touchIn <= 5'h15;
		wt(10);
		`CHK("levels", 5'h15, eventPin)
		`CHK("host edges", n + 3, rises)
		touchIn <= 5'h00;
		apb(1'b1, 8'h04, 32'h5);
		apb(1'b1, 8'h0C, 32'h6);
		apb(1'b1, 8'h2C, 32'hFFFFFF);
		apb(1'b1, 8'h30, 32'h800);
		tap(2);
		tap(2);
		rdchk(8'h2C, 32'h842);
		`CHK("irq set", 1'b1, irq)
		apb(1'b1, 8'h2C, 32'h800);
		rdchk(8'h2C, 32'h042);
		`CHK("irq masked", 1'b0, irq)
		apb(1'b1, 8'h2C, 32'hFFFFFF);
		tap(8);
		rdchk(8'h2C, 32'h10002);
		// three steps clockwise, one back
		wheelOn <= 1'b1;
		wt(4);
		for (int i = 0; i < 4; i++)
		begin
			wheelStepCw <= (i < 3);
			wheelStepCcw <= (i == 3);
			wt(4);
			{wheelStepCw, wheelStepCcw} <= 2'b00;
			wt(4);
		end
		rdchk(8'h28, 32'h2);
		apb(1'b1, 8'h2C, 32'hFFFFFF);
		{motionOn, handPresent, circleCw, circleFound} <= 4'hF;
		wt(6);
		rdchk(8'h2C, 32'h0);
		motionOn <= 1'b0;
		wt(6);
		rdchk(8'h2C, 32'h100000);
		{handPresent, circleFound} <= 2'b00;
		// approach scheduling with two channels and a short interval
		apb(1'b1, 8'h20, 32'h3);
		apb(1'b1, 8'h10, 32'h3);
		apb(1'b1, 8'h18, 32'h1);
		apb(1'b1, 8'h1C, 32'h0);
		apb(1'b1, 8'h00, 32'h3);
		// state moves one edge after the write, its output one more
		wt(2);
		`CHK("sleep", 1'b1, sleepState)
		waitfor(0, 10 * MS);
		`CHK("approach mask", 5'h03, rxEnable)
		waitfor(1, 5 * MS);
		waitfor(0, 10 * MS);
		`CHK("interval", 1'b1, n >= 2 * MS && n <= 5 * MS)
		waitfor(2, 1200 * MS);
		`CHK("calib late", 1'b1, rxEnable === 5'h1F)
		rxExceed <= 5'h02;
		waitfor(3, 20 * MS);
		`CHK("wake", 1'b1, hostWake)
		rxExceed <= 5'h00;
		end_of_test();
	end
endmodule
`default_nettype wire
